// file: core/fcl_pkg.sv
package fcl_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_ID      = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h30;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT  = 8'h10;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'hE8;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] CMD_SET_LOCK     = 8'h01;
  localparam logic [7:0] CMD_SET_LOCKDOWN = 8'h2F;
  localparam logic [7:0] CMD_SET_CONFIG   = 8'h04;
  localparam logic [7:0] CMD_OTP_PROGRAM  = 8'hC0;

  // ----------------------------------------------------------------
  // User operation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_READ_ARRAY   = 4'h0;
  localparam logic [3:0] OP_READ_ID      = 4'h1;
  localparam logic [3:0] OP_READ_STATUS  = 4'h2;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
  localparam logic [3:0] OP_BLOCK_ERASE  = 4'h4;
  localparam logic [3:0] OP_CHIP_ERASE   = 4'h5;
  localparam logic [3:0] OP_PROGRAM      = 4'h6;
  localparam logic [3:0] OP_PAGE_PROGRAM = 4'h7;
  localparam logic [3:0] OP_SUSPEND      = 4'h8;
  localparam logic [3:0] OP_RESUME       = 4'h9;
  localparam logic [3:0] OP_SET_LOCK     = 4'hA;
  localparam logic [3:0] OP_CLEAR_LOCK   = 4'hB;
  localparam logic [3:0] OP_SET_LOCKDOWN = 4'hC;
  localparam logic [3:0] OP_OTP_PROGRAM  = 4'hD;
  localparam logic [3:0] OP_SET_CONFIG   = 4'hE;
  localparam logic [3:0] OP_READ         = 4'hF;

  // ----------------------------------------------------------------
  // Bus widths, page buffer and status fields
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 21;
  localparam int         DATA_W          = 16;
  localparam int         PAGE_DEPTH      = 16;
  localparam int         PAGE_AW         = 4;
  localparam int         STAT_READY      = 7;
  localparam int         STAT_ERASE_SUSP = 6;
  localparam int         STAT_ERASE_ERR  = 5;
  localparam int         STAT_PROG_ERR   = 4;
  localparam int         STAT_VOLT_ERR   = 3;
  localparam int         STAT_PROG_SUSP  = 2;
  localparam int         STAT_PROTECT    = 1;

  // ----------------------------------------------------------------
  // Pin timing, 200 MHz clock
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_PS   = 5000;
  localparam int         T_WE_LOW_NS     = 50;
  localparam int         T_WE_HIGH_NS    = 30;
  localparam int         T_OE_ACCESS_NS  = 80;
  localparam int         WE_LOW_CYC      = (T_WE_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  localparam int         WE_HIGH_CYC     = (T_WE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  localparam int         OE_ACCESS_CYC   = (T_OE_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1)
                                           / CLK_PERIOD_PS;
  localparam int         TIMER_W         = 6;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    FCL_IDLE  = 6'h01,
    FCL_WLOW  = 6'h02,
    FCL_WHIGH = 6'h04,
    FCL_RLOW  = 6'h08,
    FCL_NEXT  = 6'h10,
    FCL_DONE  = 6'h20
  } fcl_state_t;

endpackage

// file: core/fcl_page_mem.sv
`timescale 1ns/10ps
module fcl_page_mem (
  // Clock
  input  wire logic                            clk,
  // Write port
  input  wire logic                            wr_en,
  input  wire logic [fcl_pkg::PAGE_AW-1:0]     wr_addr,
  input  wire logic [fcl_pkg::DATA_W-1:0]      wr_data,
  // Read port
  input  wire logic [fcl_pkg::PAGE_AW-1:0]     rd_addr,
  output logic      [fcl_pkg::DATA_W-1:0]      rd_data
);

  logic [fcl_pkg::DATA_W-1:0] mem [fcl_pkg::PAGE_DEPTH];

  // Write storage
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

// file: core/fcl_host.sv
`timescale 1ns/10ps
// Contract
// - 90H then reads return identifier data
// - 70H gives status read; 50H clears
// - Erase 20H/D0H at block; chip 30H/D0H
// - Page program E8H, N-1, pairs, D0H
// - Second cycle repeats first cycle address
// - B0H suspends, D0H resumes in partition
// - Resume suspended program before suspended erase
// - Lock 60H then 01H, D0H, 2FH
// - Configuration 60H then 04H, code on address
module fcl_host (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // User command port
  input  wire logic                          cmd_valid,
  input  wire logic [3:0]                    cmd_op,
  input  wire logic [fcl_pkg::ADDR_W-1:0]    cmd_addr,
  input  wire logic [fcl_pkg::DATA_W-1:0]    cmd_data,
  input  wire logic [fcl_pkg::PAGE_AW-1:0]   cmd_count,
  output logic                               cmd_ready,
  // Page data load port
  input  wire logic                          page_wr,
  input  wire logic [fcl_pkg::PAGE_AW-1:0]   page_idx,
  input  wire logic [fcl_pkg::DATA_W-1:0]    page_data,
  // Result port
  output logic                               done,
  output logic      [fcl_pkg::DATA_W-1:0]    rd_data,
  output logic                               resume_refused,
  // Flash pins
  output logic      [fcl_pkg::ADDR_W-1:0]    flash_addr,
  input  wire logic [fcl_pkg::DATA_W-1:0]    flash_dq_in,
  output logic      [fcl_pkg::DATA_W-1:0]    flash_dq_out,
  output logic                               flash_dq_oe,
  output logic                               flash_ce_n,
  output logic                               flash_oe_n,
  output logic                               flash_we_n,
  output logic                               flash_rst_n
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Number of bus cycles for each user operation
  function automatic logic [4:0] cycles_of(input logic [3:0] op,
                                           input logic [3:0] cnt);
    case (op)
      fcl_pkg::OP_READ_ARRAY, fcl_pkg::OP_CLEAR_STATUS,
      fcl_pkg::OP_SUSPEND, fcl_pkg::OP_RESUME, fcl_pkg::OP_READ_ID: cycles_of = 5'd1;
      fcl_pkg::OP_READ, fcl_pkg::OP_READ_STATUS:                    cycles_of = 5'd1;
      fcl_pkg::OP_PAGE_PROGRAM: cycles_of = 5'(cnt) + 5'd4;
      default:                                                      cycles_of = 5'd2;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  fcl_pkg::fcl_state_t               state;
  logic [3:0]                        op;
  logic [fcl_pkg::ADDR_W-1:0]        base_addr;
  logic [fcl_pkg::DATA_W-1:0]        wdata;
  logic [fcl_pkg::PAGE_AW-1:0]       count;
  logic [4:0]                        step;
  logic [4:0]                        last_step;
  logic [fcl_pkg::TIMER_W-1:0]       timer;
  logic                              is_read;
  logic [fcl_pkg::DATA_W-1:0]        dq_s1;
  logic [fcl_pkg::DATA_W-1:0]        dq_s2;
  logic                              prog_susp;
  logic                              erase_susp;
  logic [fcl_pkg::DATA_W-1:0]        page_q;
  logic [fcl_pkg::PAGE_AW-1:0]       page_rd_idx;
  logic [7:0]                        cyc_cmd;
  logic [fcl_pkg::ADDR_W-1:0]        cyc_addr;
  logic [fcl_pkg::DATA_W-1:0]        cyc_data;

  // Page buffer staging memory
  fcl_page_mem u_page (
    .clk     (clk),
    .wr_en   (page_wr),
    .wr_addr (page_idx),
    .wr_data (page_data),
    .rd_addr (page_rd_idx),
    .rd_data (page_q)
  );

  // Page word for step k (steps 2..N+1) is index k-2; prefetch one ahead
  assign page_rd_idx = fcl_pkg::PAGE_AW'(step - 5'd1);

  // ----------------------------------------------------------------
  // Per-step command code and address
  // ----------------------------------------------------------------
  always_comb
  begin
    cyc_cmd  = fcl_pkg::CMD_READ_ARRAY;
    cyc_addr = base_addr;
    case (op)
      fcl_pkg::OP_READ_ARRAY:   cyc_cmd = fcl_pkg::CMD_READ_ARRAY;
      fcl_pkg::OP_READ_ID:      cyc_cmd = fcl_pkg::CMD_READ_ID;
      fcl_pkg::OP_READ_STATUS:  cyc_cmd = fcl_pkg::CMD_READ_STATUS;
      fcl_pkg::OP_CLEAR_STATUS: cyc_cmd = fcl_pkg::CMD_CLEAR_STATUS;
      fcl_pkg::OP_BLOCK_ERASE:  cyc_cmd = (step == 5'd0) ? fcl_pkg::CMD_BLOCK_ERASE
                                                        : fcl_pkg::CMD_CONFIRM;
      fcl_pkg::OP_CHIP_ERASE:   cyc_cmd = (step == 5'd0) ? fcl_pkg::CMD_CHIP_ERASE
                                                        : fcl_pkg::CMD_CONFIRM;
      fcl_pkg::OP_PROGRAM:      cyc_cmd = fcl_pkg::CMD_PROGRAM;
      fcl_pkg::OP_OTP_PROGRAM:  cyc_cmd = fcl_pkg::CMD_OTP_PROGRAM;
      fcl_pkg::OP_PAGE_PROGRAM:
      begin
        cyc_cmd = (step == 5'd0) ? fcl_pkg::CMD_PAGE_PROGRAM : fcl_pkg::CMD_CONFIRM;
        if (step >= 5'd2 && step != last_step)
        begin
          cyc_addr = base_addr + fcl_pkg::ADDR_W'(step - 5'd2);
        end
      end
      fcl_pkg::OP_SUSPEND:      cyc_cmd = fcl_pkg::CMD_SUSPEND;
      fcl_pkg::OP_RESUME:       cyc_cmd = fcl_pkg::CMD_CONFIRM;
      fcl_pkg::OP_SET_LOCK:     cyc_cmd = (step == 5'd0) ? fcl_pkg::CMD_LOCK_SETUP
                                                        : fcl_pkg::CMD_SET_LOCK;
      fcl_pkg::OP_CLEAR_LOCK:   cyc_cmd = (step == 5'd0) ? fcl_pkg::CMD_LOCK_SETUP
                                                        : fcl_pkg::CMD_CONFIRM;
      fcl_pkg::OP_SET_LOCKDOWN: cyc_cmd = (step == 5'd0) ? fcl_pkg::CMD_LOCK_SETUP
                                                        : fcl_pkg::CMD_SET_LOCKDOWN;
      fcl_pkg::OP_SET_CONFIG:   cyc_cmd = (step == 5'd0) ? fcl_pkg::CMD_LOCK_SETUP
                                                        : fcl_pkg::CMD_SET_CONFIG;
      default:                  cyc_cmd = fcl_pkg::CMD_READ_ARRAY;
    endcase
  end

  // Data word per step: user data on program data cycles, page words, count
  always_comb
  begin
    cyc_data = {8'h00, cyc_cmd};
    if ((op == fcl_pkg::OP_PROGRAM || op == fcl_pkg::OP_OTP_PROGRAM) && step == 5'd1)
    begin
      cyc_data = wdata;
    end
    else if (op == fcl_pkg::OP_PAGE_PROGRAM && step == 5'd1)
    begin
      cyc_data = fcl_pkg::DATA_W'(count);
    end
    else if (op == fcl_pkg::OP_PAGE_PROGRAM && step >= 5'd2 && step != last_step)
    begin
      cyc_data = page_q;
    end
  end

  // ----------------------------------------------------------------
  // Data pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end
    else
    begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // ----------------------------------------------------------------
  // Suspend bookkeeping and resume ordering
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_susp  <= 1'b0;
      erase_susp <= 1'b0;
    end
    else if (state == fcl_pkg::FCL_IDLE && cmd_valid && cmd_ready)
    begin
      if (cmd_op == fcl_pkg::OP_SUSPEND)
      begin
        prog_susp  <= cmd_data[0] | prog_susp;
        erase_susp <= ~cmd_data[0] | erase_susp;
      end
      else if (cmd_op == fcl_pkg::OP_RESUME && cmd_data[0])
      begin
        prog_susp <= 1'b0;
      end
      else if (cmd_op == fcl_pkg::OP_RESUME && !prog_susp)
      begin
        // A refused erase resume leaves both flags parked
        erase_susp <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state          <= fcl_pkg::FCL_IDLE;
      op             <= 4'h0;
      base_addr      <= '0;
      wdata          <= 16'h0000;
      count          <= '0;
      step           <= 5'd0;
      last_step      <= 5'd0;
      timer          <= '0;
      is_read        <= 1'b0;
      cmd_ready      <= 1'b0;
      done           <= 1'b0;
      rd_data        <= 16'h0000;
      resume_refused <= 1'b0;
      flash_addr     <= '0;
      flash_dq_out   <= 16'h0000;
      flash_dq_oe    <= 1'b0;
      flash_ce_n     <= 1'b1;
      flash_oe_n     <= 1'b1;
      flash_we_n     <= 1'b1;
      flash_rst_n    <= 1'b0;
    end
    else
    begin
      done           <= 1'b0;
      resume_refused <= 1'b0;
      flash_rst_n    <= 1'b1;
      case (state)
        fcl_pkg::FCL_IDLE:
        begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            op        <= cmd_op;
            base_addr <= cmd_addr;
            wdata     <= cmd_data;
            count     <= cmd_count;
            step      <= 5'd0;
            last_step <= cycles_of(cmd_op, cmd_count) - 5'd1;
            is_read   <= (cmd_op == fcl_pkg::OP_READ);
            // A resume with a program and an erase both parked must target the program
            if (cmd_op == fcl_pkg::OP_RESUME && prog_susp && erase_susp && !cmd_data[0])
            begin
              resume_refused <= 1'b1;
              done           <= 1'b1;
            end
            else
            begin
              state <= fcl_pkg::FCL_NEXT;
            end
          end
        end
        fcl_pkg::FCL_NEXT:
        begin
          // Same address on every cycle of a two-cycle command
          flash_addr <= cyc_addr;
          flash_ce_n <= 1'b0;
          timer      <= '0;
          if (is_read)
          begin
            flash_oe_n <= 1'b0;
            state      <= fcl_pkg::FCL_RLOW;
          end
          else
          begin
            flash_dq_out <= cyc_data;
            flash_dq_oe  <= 1'b1;
            flash_we_n   <= 1'b0;
            state        <= fcl_pkg::FCL_WLOW;
          end
        end
        fcl_pkg::FCL_WLOW:
        begin
          timer <= timer + 1'b1;
          if (timer == fcl_pkg::TIMER_W'(fcl_pkg::WE_LOW_CYC - 1))
          begin
            // Strobe rises before chip select so data is latched on the strobe
            flash_we_n <= 1'b1;
            timer      <= '0;
            state      <= fcl_pkg::FCL_WHIGH;
          end
        end
        fcl_pkg::FCL_WHIGH:
        begin
          flash_ce_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          timer       <= timer + 1'b1;
          if (timer == fcl_pkg::TIMER_W'(fcl_pkg::WE_HIGH_CYC - 1))
          begin
            step  <= step + 5'd1;
            state <= (step == last_step) ? fcl_pkg::FCL_DONE : fcl_pkg::FCL_NEXT;
          end
        end
        fcl_pkg::FCL_RLOW:
        begin
          timer <= timer + 1'b1;
          // Two extra cycles cover the data pin synchroniser
          if (timer == fcl_pkg::TIMER_W'(fcl_pkg::OE_ACCESS_CYC + 1))
          begin
            rd_data    <= dq_s2;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            state      <= fcl_pkg::FCL_DONE;
          end
        end
        fcl_pkg::FCL_DONE:
        begin
          done  <= 1'b1;
          state <= fcl_pkg::FCL_IDLE;
        end
        default:
        begin
          state <= fcl_pkg::FCL_IDLE;
        end
      endcase
    end
  end

endmodule

// file: test/fcl_host_properties.sv
`timescale 1ns/10ps
// ----------------------------------------
// Pin and handshake checks of the host
// ----------------------------------------
module fcl_host_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Handshake
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        done,
  input wire logic        resume_refused,
  // Flash pins
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Strobe low for ten cycles, then high
  sequence s_we_low;
    (!flash_we_n)[*8] ##1 (!flash_we_n)[*2] ##1 flash_we_n;
  endsequence
  a_we_width: assert property ($fell(flash_we_n) |-> s_we_low)
    else $error("Write strobe width wrong");
  a_no_fight: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("Output and write strobes low together");
  a_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("Write strobe outside a driven select");
  a_write_stable: assert property (!flash_we_n && $past(!flash_we_n)
    |-> $stable(flash_dq_out) && $stable(flash_addr))
    else $error("Write data or address moved under the strobe");
  a_we_first: assert property ($rose(flash_we_n) |-> !flash_ce_n)
    else $error("Select rose before the write strobe");
  a_take_drops: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("Ready stayed high after a take");
  a_take_done: assert property (cmd_valid && cmd_ready |-> ##[1:400] done)
    else $error("Operation never finished");
  a_done_pulse: assert property (done |=> !done && cmd_ready)
    else $error("Done not a single pulse before ready");
  a_refuse_quiet: assert property (resume_refused |-> done && flash_ce_n)
    else $error("Refused resume touched the pins");
endmodule
bind fcl_host fcl_host_properties fcl_host_properties_inst (
  .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .done(done),
  .resume_refused(resume_refused), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n));

// file: test/fcl_flash_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Behavioural flash device
// ----------------------------------------
module fcl_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h5A3C  // Arbitrary identity value
) (
  // Flash pins
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq_wr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic        wp,
  output logic      [15:0] dq_rd,
  // Sequence faults seen
  output logic      [7:0]  seq_errors
);
  logic [15:0] mem [logic [20:0]];
  logic [63:0] lk, ld, from_open;
  logic [15:0] stat, cfg, data, last = 16'h0000;
  logic [7:0]  pend, dv;
  logic [20:0] paddr;
  logic [5:0]  b;
  logic [1:0]  mode;
  logic        wp_seen, susp;
  int          cnt;
  assign dv = dq_wr[7:0];
  assign b = addr[20:15];
  // Erase a whole block or program one place, refused on a locked block
  task automatic alter(input logic [20:0] a, input logic [15:0] d, input bit erase);
    stat[3] = 1'h0;
    if (lk[a[20:15]])
      stat[1] = 1'h1;
    if (lk[a[20:15]])
      stat[erase ? 5 : 4] = 1'h1;
    else if (erase)
    begin
      foreach (mem[k]) if (k[20:15] == a[20:15]) mem[k] = 16'hFFFF;
    end
    else
      mem[a] = d;
  endtask
  // Commands latched at the strobe's rising edge, protect level changes
  always @(posedge we_n or negedge rst_n or posedge wp or negedge wp)
  begin
    if (!rst_n)
    begin
      lk = '1;
      ld = '0;
      from_open = '0;
      stat = 16'h0080;
      {pend, mode, susp, seq_errors, cfg} = '0;
      wp_seen = wp;
    end
    else if (wp !== wp_seen)
    begin
      for (int i = 0; i < 64; i++)
        if (ld[i] && wp)
          lk[i] = !from_open[i];
        else if (ld[i])
        begin
          from_open[i] = !lk[i];
          lk[i] = 1'h1;
        end
      wp_seen = wp;
    end
    else if (!ce_n && pend == 8'h00)
      case (dv)
        8'h70: mode = 2'h2;
        8'h90: mode = 2'h1;
        8'hFF: mode = 2'h0;
        8'h50: stat[5:1] = '0;
        8'hB0: susp = 1'h1;
        8'hD0: susp = 1'h0;
        default:
        begin
          pend = dv;
          paddr = addr;
          cnt = -1;
        end
      endcase
    else if (!ce_n)
    begin
      if (pend != 8'hE8 && addr !== paddr)
        seq_errors++;
      case (pend)
        8'h20: alter(addr, 16'hFFFF, 1'h1);
        8'h30: foreach (mem[k]) if (!lk[k[20:15]]) mem[k] = 16'hFFFF;
        8'h40, 8'h10: alter(addr, dq_wr, 1'h0);
        8'hC0: if (!susp) mem[addr] = dq_wr;
        8'h60:
          case (dv)
            8'h01: if (!ld[b] || wp) lk[b] = 1'h1;
            8'h2F: if (!ld[b] || wp) {ld[b], lk[b]} = 2'h3;
            8'hD0: if (!ld[b] || wp) lk[b] = 1'h0;
            8'h04: cfg = addr[15:0];
            default: seq_errors++;
          endcase
        8'hE8:
          if (cnt == -1)
            cnt = dq_wr + 1;
          else if (cnt > 0)
          begin
            alter(addr, dq_wr, 1'h0);
            cnt--;
          end
          else
          begin
            if (dv != 8'hD0)
              seq_errors++;
            cnt = -2;
          end
        default: seq_errors++;
      endcase
      if (pend != 8'hE8 || cnt == -2)
        {pend, mode} = {8'h00, 2'h2};
    end
  end
  // Read data, inverse of the last value once released
  always @*
  begin
    data = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    if (mode == 2'h2)
      data = stat;
    else if (mode == 2'h1)
      data = addr[7:0] == 8'h00 ? MAKER_CODE : addr[7:0] == 8'h06 ? cfg
           : {14'h0, ld[b], lk[b]};
  end
  always @(posedge oe_n) last <= data;
  assign dq_rd = (!ce_n && !oe_n) ? data : ~last;
endmodule

// file: test/tb.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host controller testbench
// ----------------------------------------
module tb;
  localparam logic [15:0] MAKER = 16'h5A3C;  // Arbitrary identity value
  localparam logic [20:0] B1    = 21'h008000;
  localparam logic [20:0] B2    = 21'h010000;
  logic        clk = 1'h0;
  logic        rst_n, cmd_valid, cmd_ready, page_wr, done, rfs, refused, wp;
  logic [3:0]  cmd_op, cmd_count, page_idx;
  logic [20:0] cmd_addr, f_addr;
  logic [15:0] cmd_data, page_data, rd_data, dq_in, dq_out;
  logic        dq_oe, ce_n, oe_n, we_n, f_rst_n;
  logic [7:0]  seq_errors;
  int          errors = 0, check_count = 0, cycles = 0;
  // Clock and instances
  always #2.5 clk = ~clk;
  fcl_host fcl_host_inst (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_count(cmd_count), .cmd_ready(cmd_ready),
    .page_wr(page_wr), .page_idx(page_idx), .page_data(page_data), .done(done),
    .rd_data(rd_data), .resume_refused(rfs), .flash_addr(f_addr), .flash_dq_in(dq_in),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_rst_n(f_rst_n));
  fcl_flash_model #(.MAKER_CODE(MAKER)) fcl_flash_model_inst (.addr(f_addr), .dq_wr(dq_out),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_n(f_rst_n), .wp(wp), .dq_rd(dq_in),
    .seq_errors(seq_errors));
  // Comparison and report
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One user operation, up to its done pulse
  task automatic run(input logic [3:0] op, input logic [20:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'h1;
    do @(negedge clk); while (cmd_ready !== 1'h1);
    @(posedge clk);
    cmd_valid <= 1'h0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (done !== 1'h1 && n < 500);
    if (n >= 500)
      errors++;
    refused = rfs;
    @(posedge clk);
  endtask
  task automatic expect_rd(input string what, input logic [3:0] mode, input logic [20:0] a,
                           input logic [15:0] exp);
    run(mode, a, 16'h0000);
    run(fcl_pkg::OP_READ, a, 16'h0000);
    check(what, rd_data, exp);
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      final_report();
    end
  end
  // Main sequence
  initial
  begin
    {rst_n, cmd_valid, page_wr, wp} <= 4'h0;
    {cmd_op, cmd_count, page_idx} <= 12'h000;
    {cmd_addr, cmd_data, page_data} <= 53'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    expect_rd("maker code", fcl_pkg::OP_READ_ID, 21'h0, MAKER);
    expect_rd("reset lock", fcl_pkg::OP_READ_ID, B1 + 2, 16'h0001);
    run(fcl_pkg::OP_PROGRAM, B1, 16'h1234);
    expect_rd("locked program", fcl_pkg::OP_READ_STATUS, B1, 16'h0092);
    run(fcl_pkg::OP_CLEAR_STATUS, B1, 16'h0000);
    expect_rd("cleared status", fcl_pkg::OP_READ_STATUS, B1, 16'h0080);
    run(fcl_pkg::OP_CLEAR_LOCK, B1, 16'h0000);
    run(fcl_pkg::OP_CLEAR_LOCK, B2, 16'h0000);
    expect_rd("clear lock", fcl_pkg::OP_READ_ID, B1 + 2, 16'h0000);
    run(fcl_pkg::OP_PROGRAM, B1 + 5, 16'hABCD);
    expect_rd("program", fcl_pkg::OP_READ_ARRAY, B1 + 5, 16'hABCD);
    run(fcl_pkg::OP_BLOCK_ERASE, B1, 16'h0000);
    expect_rd("block erase", fcl_pkg::OP_READ_ARRAY, B1 + 5, 16'hFFFF);
    page_wr <= 1'h1;
    page_data <= 16'h1111;
    @(posedge clk);
    page_idx <= 4'h1;
    page_data <= 16'h2222;
    @(posedge clk);
    page_wr <= 1'h0;
    cmd_count <= 4'h1;
    run(fcl_pkg::OP_PAGE_PROGRAM, B2, 16'h0000);
    expect_rd("page word 0", fcl_pkg::OP_READ_ARRAY, B2, 16'h1111);
    run(fcl_pkg::OP_READ, B2 + 1, 16'h0000);
    check("page word 1", rd_data, 16'h2222);
    run(fcl_pkg::OP_SET_LOCK, B2, 16'h0000);
    expect_rd("set lock", fcl_pkg::OP_READ_ID, B2 + 2, 16'h0001);
    run(fcl_pkg::OP_PROGRAM, B1 + 5, 16'h5555);
    run(fcl_pkg::OP_CHIP_ERASE, 21'h0, 16'h0000);
    expect_rd("chip erase", fcl_pkg::OP_READ_ARRAY, B1 + 5, 16'hFFFF);
    expect_rd("locked survives", fcl_pkg::OP_READ_ARRAY, B2, 16'h1111);
    run(fcl_pkg::OP_SET_LOCKDOWN, B1, 16'h0000);
    expect_rd("lock-down", fcl_pkg::OP_READ_ID, B1 + 2, 16'h0003);
    run(fcl_pkg::OP_CLEAR_LOCK, B1, 16'h0000);
    expect_rd("held down", fcl_pkg::OP_READ_ID, B1 + 2, 16'h0003);
    wp <= 1'h1;
    expect_rd("protect rise", fcl_pkg::OP_READ_ID, B1 + 2, 16'h0003);
    run(fcl_pkg::OP_CLEAR_LOCK, B1, 16'h0000);
    expect_rd("open clear", fcl_pkg::OP_READ_ID, B1 + 2, 16'h0002);
    wp <= 1'h0;
    expect_rd("protect fall", fcl_pkg::OP_READ_ID, B1 + 2, 16'h0003);
    wp <= 1'h1;
    expect_rd("reopen", fcl_pkg::OP_READ_ID, B1 + 2, 16'h0002);
    expect_rd("plain lock kept", fcl_pkg::OP_READ_ID, B2 + 2, 16'h0001);
    run(fcl_pkg::OP_SET_CONFIG, 21'h000007, 16'h0000);
    expect_rd("config code", fcl_pkg::OP_READ_ID, 21'h000006, 16'h0007);
    run(fcl_pkg::OP_SUSPEND, B1, 16'h0001);
    run(fcl_pkg::OP_SUSPEND, B2, 16'h0000);
    run(fcl_pkg::OP_OTP_PROGRAM, 21'h000081, 16'h4321);
    expect_rd("otp in suspend", fcl_pkg::OP_READ_ARRAY, 21'h000081, 16'hFFFF);
    run(fcl_pkg::OP_RESUME, B2, 16'h0000);
    check("early erase resume", {15'h0, refused}, 16'h0001);
    run(fcl_pkg::OP_RESUME, B2, 16'h0000);
    check("erase resume again", {15'h0, refused}, 16'h0001);
    run(fcl_pkg::OP_RESUME, B1, 16'h0001);
    run(fcl_pkg::OP_RESUME, B2, 16'h0000);
    check("later erase resume", {15'h0, refused}, 16'h0000);
    run(fcl_pkg::OP_OTP_PROGRAM, 21'h000081, 16'h4321);
    expect_rd("otp program", fcl_pkg::OP_READ_ARRAY, 21'h000081, 16'h4321);
    check("write pairing", {8'h00, seq_errors}, 16'h0000);
    final_report();
  end
endmodule
